/* verilog/clb_cpu_end.sv */
// Purpose: Processor end of the local bus: cycles, hold, float, interrupt
// Assumes: Core clock is the double-rate clock, inputs synchronous
// Notes:   User side issues one request at a time
`timescale 1ns/100ps
`default_nettype none
module clb_cpu_end (
  // Clock and reset
  input  wire logic                      core_clk_i,
  input  wire logic                      rst_i,
  // Request side
  input  wire logic                      req_valid_i,
  input  wire clb_pkg::clb_kind_e        req_kind_i,
  input  wire logic [clb_pkg::ADDR_W-1:0] req_addr_i,
  input  wire logic [1:0]                req_ben_i,
  input  wire logic [clb_pkg::DATA_W-1:0] req_wdata_i,
  input  wire logic                      irq_enable_i,
  output logic                           req_ready_o,
  output logic                           done_o,
  output logic [clb_pkg::DATA_W-1:0]     rdata_o,
  output logic                           irq_taken_o,
  output logic                           pipe_hint_o,
  output logic                           coproc_busy_o,
  output logic                           coproc_error_o,
  output logic                           coproc_req_o,
  // Bus pins
  clb_if.cpu                             bus
);
  import clb_pkg::*;

  typedef enum logic [1:0] {CLB_IDLE, CLB_ADDR, CLB_DATA, CLB_HELD} clb_state_e;
  clb_state_e state_q, state_d;
  clb_kind_e  kind_q;

  logic [ADDR_W-1:0] addr_q;
  logic [1:0]        ben_q;
  logic [DATA_W-1:0] wdata_q;
  logic              ads_q;
  logic              aoe_q;
  logic              doe_q;
  logic              bus_takeover_grant_q;
  logic              rdy_q;
  logic              done_q;
  logic              irq_q;
  logic              pipe_q;
  logic [DATA_W-1:0] rdata_q;
  logic              busy_q;
  logic              err_q;
  logic              preq_q;

  function automatic logic kind_is_write(input clb_kind_e k);
    return (k == CLB_MEM_WR) || (k == CLB_IO_WR);
  endfunction

  function automatic logic kind_is_mem(input clb_kind_e k);
    return (k == CLB_MEM_RD) || (k == CLB_MEM_WR) || (k == CLB_CODE_RD) || (k == CLB_HALT);
  endfunction

  function automatic logic kind_is_data(input clb_kind_e k);
    return (k == CLB_MEM_RD) || (k == CLB_MEM_WR) || (k == CLB_IO_RD) || (k == CLB_IO_WR);
  endfunction

  wire float_w    = ~bus.tristate_force_n;
  wire irq_go_w   = bus.maskable_irq & irq_enable_i;
  // No new cycle under float: a hidden strobe would leave this end waiting for ready forever
  wire start_w    = (state_q == CLB_IDLE) & ~bus.hold_req & ~float_w & (req_valid_i | irq_go_w);
  wire clb_kind_e start_kind_w = irq_go_w ? CLB_INT_ACK : req_kind_i;
  wire [1:0] start_ben_w = irq_go_w ? 2'h1 : req_ben_i;
  wire end_w      = (state_q == CLB_DATA) & ~bus.ready_n;
  wire is_wr_w    = kind_is_write(kind_q);
  wire is_mem_w   = kind_is_mem(kind_q);
  wire is_data_w  = kind_is_data(kind_q);
  wire is_rd_w    = ~is_wr_w;
  wire addr_ph_w  = (state_d == CLB_ADDR);
  wire data_ph_w  = (state_d == CLB_DATA);

  // Interrupt preempts the user request, acknowledge reads vector low byte
  always_comb begin
    state_d = state_q;
    case (state_q)
      CLB_IDLE: begin
        if (bus.hold_req) begin
          state_d = CLB_HELD;
        end else if (start_w) begin
          state_d = CLB_ADDR;
        end
      end
      CLB_ADDR: state_d = CLB_DATA;
      CLB_DATA: begin
        if (end_w) begin
          state_d = CLB_IDLE;
        end
      end
      CLB_HELD: begin
        if (!bus.hold_req) begin
          state_d = CLB_IDLE;
        end
      end
      default: state_d = CLB_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_q <= CLB_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      kind_q  <= CLB_HALT;
      addr_q  <= ADDR_RST;
      ben_q   <= 2'h0;
      wdata_q <= DATA_RST;
      irq_q   <= 1'b0;
    end else begin
      irq_q <= start_w & irq_go_w;
      if (start_w) begin
        kind_q  <= start_kind_w;
        addr_q  <= irq_go_w ? ADDR_RST : req_addr_i;
        ben_q   <= start_ben_w;
        wdata_q <= req_wdata_i;
      end
    end
  end

  // Strobe and definition launch together in the address phase
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ads_q  <= 1'b0;
      aoe_q  <= 1'b0;
      doe_q  <= 1'b0;
      bus_takeover_grant_q <= 1'b0;
    end else begin
      ads_q  <= addr_ph_w & ~float_w;
      aoe_q  <= (addr_ph_w | data_ph_w) & ~float_w;
      doe_q  <= data_ph_w & is_wr_w & ~float_w;
      // Grant rises only after the bus outputs are already off
      bus_takeover_grant_q <= (state_q == CLB_HELD) & bus.hold_req & ~aoe_q;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rdy_q   <= 1'b0;
      done_q  <= 1'b0;
      rdata_q <= DATA_RST;
      pipe_q  <= 1'b0;
    end else begin
      rdy_q  <= (state_d == CLB_IDLE) & ~bus.hold_req & ~float_w;
      done_q <= end_w;
      if (end_w && is_rd_w) begin
        rdata_q <= bus.data_lines;
      end
      pipe_q <= (state_q == CLB_DATA) & ~bus.pipeline_req_n;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      busy_q <= 1'b0;
      err_q  <= 1'b0;
      preq_q <= 1'b0;
    end else begin
      busy_q <= ~bus.coproc_busy_n;
      err_q  <= ~bus.coproc_error_n;
      preq_q <= bus.coproc_xfer_request;
    end
  end

  assign bus.addr_strobe_n    = ~ads_q;
  assign bus.addr_oe          = aoe_q;
  assign bus.word_addr_out    = addr_q;
  assign bus.upper_byte_en_n  = ~ben_q[1];
  assign bus.lower_byte_en_n  = ~ben_q[0];
  assign bus.mem_io_sel       = is_mem_w;
  assign bus.data_ctl_sel     = is_data_w;
  assign bus.wr_rd_sel        = is_wr_w;
  assign bus.cpu_data_out     = wdata_q;
  assign bus.cpu_data_oe      = doe_q;
  assign bus.bus_takeover_grant = bus_takeover_grant_q;
  // Grant pin floats too while float is held
  assign bus.grant_oe         = ~float_w;

  assign req_ready_o    = rdy_q;
  assign done_o         = done_q;
  assign rdata_o        = rdata_q;
  assign irq_taken_o    = irq_q;
  assign pipe_hint_o    = pipe_q;
  assign coproc_busy_o  = busy_q;
  assign coproc_error_o = err_q;
  assign coproc_req_o   = preq_q;
endmodule : clb_cpu_end
`default_nettype wire

/* verilog/clb_pkg.sv */
// Purpose: Shared constants and types for the local bus ends
// Assumes: One 10 MHz clock, synchronous active-high reset
// Notes:   Active-low pins carry _n in their names
package clb_pkg;
  localparam int ADDR_W   = 23;
  localparam int DATA_W   = 16;
  localparam int ADDR_LSB = 1;
  // Bus cycle kinds issued by the processor end
  typedef enum logic [2:0] {
    CLB_MEM_RD,
    CLB_MEM_WR,
    CLB_IO_RD,
    CLB_IO_WR,
    CLB_CODE_RD,
    CLB_INT_ACK,
    CLB_HALT
  } clb_kind_e;
  localparam logic [ADDR_W-1:0] ADDR_RST = 23'h000000;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  // Arbitrary value, no identity meaning
  localparam logic [7:0] CLB_ID_VAL = 8'h5a;
  // Wait states the memory end inserts before ready
  localparam logic [1:0] MEM_WAIT = 2'h1;
endpackage : clb_pkg

/* verilog/clb_if.sv */
// Purpose: Pin-level carrier between processor end and system end
// Assumes: Both ends on one clock
// Notes:   Data lines resolved here from the two enables
`timescale 1ns/100ps
`default_nettype none
interface clb_if;
  import clb_pkg::*;
  logic              addr_strobe_n;
  logic              addr_oe;
  logic [ADDR_W-1:0] word_addr_out;
  logic              upper_byte_en_n;
  logic              lower_byte_en_n;
  logic              mem_io_sel;
  logic              data_ctl_sel;
  logic              wr_rd_sel;
  logic [DATA_W-1:0] cpu_data_out;
  logic              cpu_data_oe;
  logic [DATA_W-1:0] sys_data_out;
  logic              sys_data_oe;
  logic [DATA_W-1:0] data_lines;
  logic              ready_n;
  logic              pipeline_req_n;
  logic              hold_req;
  logic              bus_takeover_grant;
  logic              grant_oe;
  logic              tristate_force_n;
  logic              maskable_irq;
  logic              coproc_busy_n;
  logic              coproc_error_n;
  logic              coproc_xfer_request;
  // Float or idle reads as zero, no pull modelling
  assign data_lines = cpu_data_oe ? cpu_data_out : (sys_data_oe ? sys_data_out : DATA_RST);
  modport cpu (
    output addr_strobe_n, addr_oe, word_addr_out, upper_byte_en_n, lower_byte_en_n,
    output mem_io_sel, data_ctl_sel, wr_rd_sel, cpu_data_out, cpu_data_oe,
    output bus_takeover_grant, grant_oe,
    input  data_lines, ready_n, pipeline_req_n, hold_req, tristate_force_n,
    input  maskable_irq, coproc_busy_n, coproc_error_n, coproc_xfer_request
  );
  modport sys (
    input  addr_strobe_n, addr_oe, word_addr_out, upper_byte_en_n, lower_byte_en_n,
    input  mem_io_sel, data_ctl_sel, wr_rd_sel, bus_takeover_grant, grant_oe, data_lines,
    output sys_data_out, sys_data_oe, ready_n, pipeline_req_n, hold_req,
    output tristate_force_n, maskable_irq, coproc_busy_n, coproc_error_n, coproc_xfer_request
  );
endinterface : clb_if
`default_nettype wire

/* verilog/clb_sys_end.sv */
// Purpose: System end: memory responder, hold master, side-band inputs
// Assumes: One clock shared with the processor end
// Notes:   Small word array stands in for memory and ports
`timescale 1ns/100ps
`default_nettype none
module clb_sys_end (
  // Clock and reset
  input  wire logic                       core_clk_i,
  input  wire logic                       rst_i,
  // Control from user side
  input  wire logic                       hold_want_i,
  input  wire logic                       float_i,
  input  wire logic                       irq_i,
  input  wire logic                       pipe_i,
  input  wire logic                       cop_busy_i,
  input  wire logic                       cop_error_i,
  input  wire logic                       cop_xfer_i,
  input  wire logic [7:0]                 irq_vector_i,
  output logic                            granted_o,
  output logic                            wr_seen_o,
  output logic [clb_pkg::DATA_W-1:0]      wr_data_o,
  // Bus pins
  clb_if.sys                              bus
);
  import clb_pkg::*;

  logic [DATA_W-1:0] mem_q [0:15];
  logic [ADDR_W-1:0] addr_q;
  logic              act_q, wr_q, ia_q, drv_q, rdy_q;
  logic [1:0]        wait_q;
  logic [DATA_W-1:0] rd_q, wd_q;
  logic              gnt_q, ws_q;
  logic              hold_q, flt_q, irq_q, pipe_q, busy_q, err_q, xfer_q;

  wire strobe_w = ~bus.addr_strobe_n & bus.addr_oe;
  wire fin_w    = act_q & (wait_q == MEM_WAIT);
  wire ia_w     = ~bus.data_ctl_sel & ~bus.mem_io_sel;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      act_q  <= 1'b0;
      addr_q <= ADDR_RST;
      wr_q   <= 1'b0;
      ia_q   <= 1'b0;
      wait_q <= 2'h0;
      rdy_q  <= 1'b0;
      drv_q  <= 1'b0;
      rd_q   <= DATA_RST;
      ws_q   <= 1'b0;
      wd_q   <= DATA_RST;
    end else begin
      rdy_q <= fin_w;
      ws_q  <= 1'b0;
      if (strobe_w) begin
        act_q  <= 1'b1;
        addr_q <= bus.word_addr_out;
        wr_q   <= bus.wr_rd_sel;
        ia_q   <= ia_w;
        wait_q <= 2'h0;
      end else if (fin_w) begin
        act_q <= 1'b0;
        if (wr_q) begin
          mem_q[addr_q[3:0]] <= bus.data_lines;
          ws_q <= 1'b1;
          wd_q <= bus.data_lines;
        end
      end else if (act_q) begin
        wait_q <= wait_q + 2'h1;
      end
      // Only read-type cycles get driven data, never writes
      drv_q <= fin_w & ~wr_q;
      rd_q  <= ia_q ? {8'h00, irq_vector_i} : mem_q[addr_q[3:0]];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      hold_q <= 1'b0;
      flt_q  <= 1'b0;
      irq_q  <= 1'b0;
      pipe_q <= 1'b0;
      busy_q <= 1'b0;
      err_q  <= 1'b0;
      xfer_q <= 1'b0;
      gnt_q  <= 1'b0;
    end else begin
      hold_q <= hold_want_i;
      gnt_q  <= bus.bus_takeover_grant & bus.grant_oe;
      flt_q  <= float_i;
      irq_q  <= irq_i;
      pipe_q <= pipe_i;
      busy_q <= cop_busy_i;
      err_q  <= cop_error_i;
      xfer_q <= cop_xfer_i;
    end
  end

  assign bus.sys_data_out        = rd_q;
  assign bus.sys_data_oe         = drv_q;
  assign bus.ready_n             = ~rdy_q;
  assign bus.pipeline_req_n      = ~pipe_q;
  assign bus.hold_req            = hold_q;
  assign bus.tristate_force_n    = ~flt_q;
  assign bus.maskable_irq        = irq_q;
  assign bus.coproc_busy_n       = ~busy_q;
  assign bus.coproc_error_n      = ~err_q;
  assign bus.coproc_xfer_request = xfer_q;
  assign granted_o               = gnt_q;
  assign wr_seen_o               = ws_q;
  assign wr_data_o               = wd_q;
endmodule : clb_sys_end
`default_nettype wire

/* verif/clb_props.sv */
// Purpose: Pin-level checker for the local bus between both ends
// Assumes: One clock, synchronous active-high reset
// Notes:   Instanced beside the interface, no bind
`timescale 1ns/100ps
`default_nettype none
module clb_props (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Cycle definition
  input wire logic addr_strobe_n,
  input wire logic addr_oe,
  input wire logic mem_io_sel,
  input wire logic data_ctl_sel,
  input wire logic wr_rd_sel,
  input wire logic upper_byte_en_n,
  input wire logic lower_byte_en_n,
  // Data and arbitration
  input wire logic cpu_data_oe,
  input wire logic sys_data_oe,
  input wire logic bus_takeover_grant,
  input wire logic grant_oe,
  input wire logic tristate_force_n,
  input wire logic hold_req
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  property p_strobe_def; !addr_strobe_n |-> addr_oe; endproperty
  property p_strobe_one; !addr_strobe_n |=> addr_strobe_n; endproperty
  property p_ack_def; !addr_strobe_n && !mem_io_sel && !data_ctl_sel |->
    !wr_rd_sel && upper_byte_en_n && !lower_byte_en_n; endproperty
  property p_wr_drive; !addr_strobe_n && wr_rd_sel && data_ctl_sel && tristate_force_n |=> cpu_data_oe; endproperty
  property p_rd_quiet; !addr_strobe_n && !wr_rd_sel && data_ctl_sel |=> !cpu_data_oe [*3]; endproperty
  property p_sys_read; sys_data_oe |-> addr_oe && !wr_rd_sel; endproperty
  property p_no_clash; !(cpu_data_oe && sys_data_oe); endproperty
  // Two samples allow one register stage inside the processor end
  property p_float; !tristate_force_n [*2] |-> !addr_oe && !cpu_data_oe && !grant_oe && addr_strobe_n; endproperty
  property p_grant_free; bus_takeover_grant |-> !addr_oe && addr_strobe_n && !cpu_data_oe; endproperty
  property p_hold_ans; $rose(hold_req) && tristate_force_n |-> ##[1:12] bus_takeover_grant; endproperty
  a_strobe_def: assert property (p_strobe_def)
    else $error("strobe without definition");
  a_strobe_one: assert property (p_strobe_one)
    else $error("strobe longer than one cycle");
  a_ack_def: assert property (p_ack_def)
    else $error("bad acknowledge definition");
  a_wr_drive: assert property (p_wr_drive)
    else $error("write data not driven");
  a_rd_quiet: assert property (p_rd_quiet)
    else $error("processor drives data on read");
  a_sys_read: assert property (p_sys_read)
    else $error("system drives data outside read");
  a_no_clash: assert property (p_no_clash)
    else $error("both ends drive data");
  a_float: assert property (p_float)
    else $error("output driven during float");
  a_grant_free: assert property (p_grant_free)
    else $error("grant while bus in use");
  a_hold_ans: assert property (p_hold_ans)
    else $error("hold not granted in time");
  c_write: cover property (!addr_strobe_n && wr_rd_sel);
  c_ack: cover property (!addr_strobe_n && !data_ctl_sel && !mem_io_sel);
  c_grant: cover property ($rose(bus_takeover_grant));
  c_float: cover property (!tristate_force_n && hold_req);
endmodule // clb_props
`default_nettype wire

/* verif/cpu_local_bus_signalling_bench.sv */
// Purpose: Self-checking bench for both local bus ends
// Assumes: 10 MHz clock, inputs driven on falling edges
// Notes:   Partial writes go to words never read back
`timescale 1ns/100ps
`default_nettype none
module cpu_local_bus_signalling_bench;
  import clb_pkg::*;
  typedef struct {clb_kind_e k; logic [ADDR_W-1:0] a; logic [1:0] b; logic [DATA_W-1:0] w; logic [2:0] p;} clb_row_s;
  logic              core_clk = 1'b0, rst = 1'b1, req_valid = 1'b0, irq_en = 1'b0;
  logic              hold_want = 1'b0, flt = 1'b0, irq = 1'b0, pipe = 1'b0;
  logic [2:0]        cop = 3'h0;
  clb_kind_e         kind = CLB_MEM_RD;
  logic [ADDR_W-1:0] addr = 23'h000000;
  logic [1:0]        ben = 2'h0;
  logic [DATA_W-1:0] wdata = 16'h0000, rdata, wr_data;
  logic              req_ready, done, irq_taken, pipe_hint, cb, ce, cr, granted, wr_seen;
  int                n_errors = 0, check_count = 0, n_strobe = 0, t, t0;
  // Fields: kind, address, enables, data, expected {mem_io, data_ctl, wr_rd}
  clb_row_s rows [8] = '{'{CLB_MEM_WR, 23'h000003, 2'h3, 16'ha5c3, 3'h7}, '{CLB_IO_WR, 23'h7ffff5, 2'h3, 16'h3c5a, 3'h3},
    '{CLB_MEM_RD, 23'h000003, 2'h3, 16'ha5c3, 3'h6}, '{CLB_IO_RD, 23'h7ffff5, 2'h3, 16'h3c5a, 3'h2},
    '{CLB_CODE_RD, 23'h000003, 2'h3, 16'ha5c3, 3'h4}, '{CLB_MEM_WR, 23'h400009, 2'h2, 16'hbe00, 3'h7},
    '{CLB_MEM_WR, 23'h00000a, 2'h1, 16'h00ef, 3'h7}, '{CLB_HALT, 23'h000000, 2'h3, 16'h0000, 3'h4}};
  clb_if bus ();
  clb_cpu_end i_clb_cpu_end (.core_clk_i(core_clk), .rst_i(rst), .req_valid_i(req_valid), .req_kind_i(kind),
    .req_addr_i(addr), .req_ben_i(ben), .req_wdata_i(wdata), .irq_enable_i(irq_en), .req_ready_o(req_ready),
    .done_o(done), .rdata_o(rdata), .irq_taken_o(irq_taken), .pipe_hint_o(pipe_hint), .coproc_busy_o(cb),
    .coproc_error_o(ce), .coproc_req_o(cr), .bus(bus.cpu));
  clb_sys_end i_clb_sys_end (.core_clk_i(core_clk), .rst_i(rst), .hold_want_i(hold_want), .float_i(flt),
    .irq_i(irq), .pipe_i(pipe), .cop_busy_i(cop[0]), .cop_error_i(cop[1]), .cop_xfer_i(cop[2]),
    .irq_vector_i(8'h5c), .granted_o(granted), .wr_seen_o(wr_seen), .wr_data_o(wr_data), .bus(bus.sys));
  clb_props i_clb_props (.core_clk_i(core_clk), .rst_i(rst), .addr_strobe_n(bus.addr_strobe_n),
    .addr_oe(bus.addr_oe), .mem_io_sel(bus.mem_io_sel), .data_ctl_sel(bus.data_ctl_sel),
    .wr_rd_sel(bus.wr_rd_sel), .upper_byte_en_n(bus.upper_byte_en_n), .lower_byte_en_n(bus.lower_byte_en_n),
    .cpu_data_oe(bus.cpu_data_oe), .sys_data_oe(bus.sys_data_oe), .bus_takeover_grant(bus.bus_takeover_grant),
    .grant_oe(bus.grant_oe), .tristate_force_n(bus.tristate_force_n), .hold_req(bus.hold_req));
  always #50 core_clk = ~core_clk;
  always @(negedge core_clk) if (bus.addr_strobe_n === 1'b0) n_strobe++;
  task automatic chk(input string n, input logic [22:0] e, input logic [22:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cyc(input clb_row_s r);
    logic [15:0] m, wd;
    logic ph;
    m = {{8{r.b[1]}}, {8{r.b[0]}}};
    wd = 16'hxxxx;
    ph = 1'b0;
    kind = r.k; addr = r.a; ben = r.b; wdata = r.w; req_valid = 1'b1;
    t = 0;
    while (req_ready !== 1'b1 && t < 40) begin @(negedge core_clk); t++; end
    @(negedge core_clk);
    req_valid = 1'b0;
    while (bus.addr_strobe_n !== 1'b0 && t < 40) begin @(negedge core_clk); t++; end
    chk("addr", r.a, bus.word_addr_out);
    chk("mio_dc", 23'(r.p[2:1]), 23'({bus.mem_io_sel, bus.data_ctl_sel}));
    if (r.k != CLB_HALT) begin
      chk("ben_n", {21'h0, ~r.b}, 23'({bus.upper_byte_en_n, bus.lower_byte_en_n}));
      chk("wr_rd", 23'(r.p[0]), 23'(bus.wr_rd_sel));
    end
    while (done !== 1'b1 && t < 40) begin
      @(negedge core_clk); t++;
      ph = ph | (pipe_hint === 1'b1);
      if (wr_seen === 1'b1) wd = wr_data;
    end
    chk("pipe", 23'(pipe), 23'(ph));
    if (r.k != CLB_HALT && r.p[0]) chk("wdata", 23'(r.w & m), 23'(wd & m));
    else if (r.k != CLB_HALT) chk("rdata", 23'(r.w & m), 23'(rdata & m));
    if (t >= 40) n_errors++;
  endtask
  initial begin
    tick(20);
    chk("rst_pins", 23'h8, 23'({bus.addr_strobe_n, bus.addr_oe, bus.cpu_data_oe, bus.bus_takeover_grant}));
    rst = 1'b0;
    tick(2);
    chk("ready", 23'h1, 23'(req_ready));
    // Back to back: next request waits right at done
    for (int i = 0; i < 8; i++) begin
      pipe = (i % 2 == 1) && (i < 7);
      cyc(rows[i]);
    end
    irq = 1'b1;
    t0 = n_strobe;
    tick(8);
    chk("masked", 23'(t0), 23'(n_strobe));
    irq_en = 1'b1;
    t = 0;
    while (irq_taken !== 1'b1 && t < 40) begin @(negedge core_clk); t++; end
    irq = 1'b0;
    while (done !== 1'b1 && t < 40) begin @(negedge core_clk); t++; end
    chk("vector", 23'h5c, 23'(rdata[7:0]));
    tick(6);
    chk("acks", 23'(t0 + 1), 23'(n_strobe));
    hold_want = 1'b1;
    t0 = n_strobe;
    // Hold reaches the pin one edge later; request only once the hold is seen
    tick(2);
    req_valid = 1'b1;
    tick(4);
    chk("granted", 23'h6, 23'({granted, bus.bus_takeover_grant, req_ready}));
    chk("held_off", 23'(t0), 23'(n_strobe));
    req_valid = 1'b0;
    flt = 1'b1;
    tick(4);
    chk("float", 23'h0, 23'({bus.grant_oe, bus.addr_oe, bus.cpu_data_oe}));
    flt = 1'b0;
    hold_want = 1'b0;
    tick(5);
    chk("released", 23'h1, 23'({bus.bus_takeover_grant, req_ready}));
    for (int i = 0; i < 3; i++) begin
      cop = 3'(1 << i);
      tick(3);
      chk("coproc", 23'(cop), 23'({cr, ce, cb}));
    end
    cop = 3'h0;
    if (t >= 40) n_errors++;
    wrap_up();
  end
  // Roughly thirty times the expected run length
  initial begin
    #300000;
    n_errors++;
    wrap_up();
  end
endmodule // cpu_local_bus_signalling_bench
`default_nettype wire
